/* File: design/fic_pkg.sv */
// constants and types shared by the flash programming controller
package fic_pkg;
   // register offsets
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_ADDRESS = 8'h04;
   localparam logic [7:0] OFS_DATA    = 8'h08;
   localparam logic [7:0] OFS_COMMAND = 8'h0c;
   localparam logic [7:0] OFS_TRIGGER = 8'h10;
   localparam logic [7:0] OFS_DBASE   = 8'h14;
   localparam logic [7:0] OFS_TIMING  = 8'h18;
   localparam logic [7:0] OFS_STATUS  = 8'h40;
   // control bit positions
   localparam int BIT_ENABLE = 0;
   localparam int BIT_BOOT   = 1;
   localparam int BIT_APPUEN = 3;
   localparam int BIT_CONFIG_UPDATE_ENABLE = 4;
   localparam int BIT_LOADER_UPDATE_ENABLE  = 5;
   localparam int BIT_FAIL   = 6;
   // timing register positions
   localparam int BIT_FOM_LO = 4;
   localparam int BIT_FOM_HI = 6;
   // status vector page field
   localparam int VEC_LSB = 9;
   localparam int VEC_MSB = 20;
   // command codes
   localparam logic [5:0] CMD_READ    = 6'h00;
   localparam logic [5:0] CMD_UID     = 6'h04;
   localparam logic [5:0] CMD_MAKER   = 6'h0b;
   localparam logic [5:0] CMD_PROGRAM = 6'h21;
   localparam logic [5:0] CMD_ERASE   = 6'h22;
   localparam logic [5:0] CMD_REMAP   = 6'h2e;
   // address map
   localparam logic [31:0] APP_LIMIT   = 32'h0002_0000;
   localparam logic [31:0] LDR_BASE    = 32'h0010_0000;
   localparam logic [31:0] LDR_LIMIT   = 32'h0010_2000;
   localparam logic [31:0] CFG_BASE    = 32'h0030_0000;
   localparam logic [31:0] CFG_LIMIT   = 32'h0030_0008;
   localparam logic [31:0] DBASE_SMALL = 32'h0001_f000;
   localparam logic [31:0] UID_W1      = 32'h0000_0004;
   localparam logic [31:0] UID_W2      = 32'h0000_0008;
   // reset values
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   // sequencer states, gray along idle-check-run-done
   typedef enum logic [1:0] {
      FIC_IDLE  = 2'b00,
      FIC_CHECK = 2'b01,
      FIC_RUN   = 2'b11,
      FIC_DONE  = 2'b10
   } fic_state_e;
endpackage

/* File: design/fic_ctrl.sv */
// flash programming controller: registers, checks and operation sequencer
//
// The plain strobed port is this design's own decision.
module fic_ctrl #(
   parameter logic [31:0] MAKER_CODE = 32'h0000_005a, // arbitrary value
   parameter logic        LARGE_PART = 1'b1
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   // register port
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_write_i,
   input  wire logic        reg_read_i,
   output logic [31:0]      reg_rdata_o,
   // chip strap and configuration
   input  wire logic        cold_reset_i,       // reset not cpu-only nor system
   input  wire logic [1:0]  chip_boot_selection_i,
   input  wire logic [31:0] second_config_word_i,
   input  wire logic        running_from_loader_i,
   input  wire logic        protect_unlocked_i,
   // flash array
   output logic             flash_req_o,
   output logic [5:0]       flash_cmd_o,
   output logic [31:0]      flash_addr_o,
   output logic [31:0]      flash_wdata_o,
   input  wire logic        flash_done_i,
   input  wire logic [31:0] flash_rdata_i,
   input  wire logic [95:0] unique_id_i,
   // timing and map
   output logic [1:0]       freq_opt_mode_o,
   output logic [11:0]      vector_page_map_o,
   output logic             boot_area_select_o
);

   ////////////////////////////////////////////////////////////////////////////
   // state record
   typedef struct packed {
      fic_pkg::fic_state_e st;           // sequencer state
      logic        prog_enable;          // master enable
      logic        boot_area_select;     // next boot area
      logic        app_update_enable;    // app self update
      logic        config_update_enable; // config words
      logic        loader_update_enable; // loader update
      logic        prog_fail_flag;       // sticky fail
      logic [31:0] prog_target_address;  // target address
      logic [31:0] prog_data_word;       // data word
      logic [5:0]  prog_command_code;    // command
      logic        prog_trigger_bit;     // busy
      logic        freq_opt_mode_hi;     // timing mode high
      logic        freq_opt_mode_lo;     // timing mode low
      logic [11:0] vector_page_map;      // remap page
      logic [31:0] data_area_base_address; // base, read only
      logic        boot_loaded;          // strap caught
      logic        flash_req;            // array request
      logic [31:0] rdata;                // read answer
   } fic_state_s;

   fic_state_s cur;
   fic_state_s next_cur;

   ////////////////////////////////////////////////////////////////////////////
   // address classifying, used only by the operation checks
   function automatic logic in_app(input logic [31:0] a);
      in_app = a < fic_pkg::APP_LIMIT;
   endfunction

   function automatic logic in_ldr(input logic [31:0] a);
      in_ldr = (a >= fic_pkg::LDR_BASE) && (a < fic_pkg::LDR_LIMIT);
   endfunction

   function automatic logic in_cfg(input logic [31:0] a);
      in_cfg = (a >= fic_pkg::CFG_BASE) && (a < fic_pkg::CFG_LIMIT);
   endfunction

   // combinational helpers
   logic        is_write_cmd;
   logic        is_known_cmd;
   logic        op_error;
   logic        wr_ctl;
   logic        wr_sta;
   logic [31:0] a;

   always_comb begin
      a = cur.prog_target_address;
      is_write_cmd = (cur.prog_command_code == fic_pkg::CMD_PROGRAM) ||
                     (cur.prog_command_code == fic_pkg::CMD_ERASE);
      is_known_cmd = is_write_cmd ||
                     (cur.prog_command_code == fic_pkg::CMD_READ) ||
                     (cur.prog_command_code == fic_pkg::CMD_UID) ||
                     (cur.prog_command_code == fic_pkg::CMD_MAKER) ||
                     (cur.prog_command_code == fic_pkg::CMD_REMAP);
      op_error = 1'b0;
      // application area writing itself without permission
      if (is_write_cmd && in_app(a) && !running_from_loader_i && !cur.app_update_enable) begin
         op_error = 1'b1;
      end
      // loader area writing itself, or loader locked
      if (is_write_cmd && in_ldr(a) && (running_from_loader_i || !cur.loader_update_enable)) begin
         op_error = 1'b1;
      end
      // configuration words while locked
      if (is_write_cmd && in_cfg(a) && !cur.config_update_enable) begin
         op_error = 1'b1;
      end
      // illegal destination
      if ((cur.prog_command_code == fic_pkg::CMD_READ || is_write_cmd ||
           cur.prog_command_code == fic_pkg::CMD_REMAP) &&
          !(in_app(a) || in_ldr(a) || in_cfg(a))) begin
         op_error = 1'b1;
      end
      if (cur.prog_command_code == fic_pkg::CMD_UID && a > fic_pkg::UID_W2) begin
         op_error = 1'b1;
      end
      if (!is_known_cmd) begin
         op_error = 1'b1;
      end
      wr_ctl = reg_write_i && reg_addr_i == fic_pkg::OFS_CONTROL;
      wr_sta = reg_write_i && reg_addr_i == fic_pkg::OFS_STATUS;
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      next_cur = cur;
      // catch straps once after release; async reset only loads constants
      if (!cur.boot_loaded) begin
         next_cur.boot_loaded = 1'b1;
         if (cold_reset_i) begin
            next_cur.boot_area_select = ~chip_boot_selection_i[1];
         end
         next_cur.data_area_base_address = LARGE_PART ? second_config_word_i
                                                      : fic_pkg::DBASE_SMALL;
      end
      // register writes; protected bits need the unlock
      if (wr_ctl && protect_unlocked_i) begin
         next_cur.prog_enable          = reg_wdata_i[fic_pkg::BIT_ENABLE];
         next_cur.boot_area_select     = reg_wdata_i[fic_pkg::BIT_BOOT];
         next_cur.app_update_enable    = reg_wdata_i[fic_pkg::BIT_APPUEN];
         next_cur.config_update_enable = reg_wdata_i[fic_pkg::BIT_CONFIG_UPDATE_ENABLE];
         next_cur.loader_update_enable = reg_wdata_i[fic_pkg::BIT_LOADER_UPDATE_ENABLE];
      end
      // write one clears, from either register
      if ((wr_ctl || wr_sta) && protect_unlocked_i && reg_wdata_i[fic_pkg::BIT_FAIL]) begin
         next_cur.prog_fail_flag = 1'b0;
      end
      if (reg_write_i && reg_addr_i == fic_pkg::OFS_ADDRESS) begin
         next_cur.prog_target_address = reg_wdata_i;
      end
      if (reg_write_i && reg_addr_i == fic_pkg::OFS_DATA) begin
         next_cur.prog_data_word = reg_wdata_i;
      end
      if (reg_write_i && reg_addr_i == fic_pkg::OFS_COMMAND) begin
         next_cur.prog_command_code = reg_wdata_i[5:0];
      end
      if (reg_write_i && reg_addr_i == fic_pkg::OFS_TIMING && protect_unlocked_i) begin
         next_cur.freq_opt_mode_hi = reg_wdata_i[fic_pkg::BIT_FOM_HI];
         next_cur.freq_opt_mode_lo = reg_wdata_i[fic_pkg::BIT_FOM_LO];
      end
      // sequencer
      unique case (cur.st)
         fic_pkg::FIC_IDLE: begin
            // start only when enabled; trigger bit is the busy flag
            if (reg_write_i && reg_addr_i == fic_pkg::OFS_TRIGGER && protect_unlocked_i &&
                reg_wdata_i[0] && cur.prog_enable) begin
               next_cur.prog_trigger_bit = 1'b1;
               next_cur.st = fic_pkg::FIC_CHECK;
            end
         end
         fic_pkg::FIC_CHECK: begin
            if (op_error) begin
               next_cur.prog_fail_flag = 1'b1;
               next_cur.st = fic_pkg::FIC_DONE;
            end else if (cur.prog_command_code == fic_pkg::CMD_UID) begin
               // three id words by address
               if (a == fic_pkg::UID_W1) begin
                  next_cur.prog_data_word = unique_id_i[63:32];
               end else if (a == fic_pkg::UID_W2) begin
                  next_cur.prog_data_word = unique_id_i[95:64];
               end else begin
                  next_cur.prog_data_word = unique_id_i[31:0];
               end
               next_cur.st = fic_pkg::FIC_DONE;
            end else if (cur.prog_command_code == fic_pkg::CMD_MAKER) begin
               next_cur.prog_data_word = MAKER_CODE;
               next_cur.st = fic_pkg::FIC_DONE;
            end else if (cur.prog_command_code == fic_pkg::CMD_REMAP) begin
               next_cur.vector_page_map = a[20:9];
               next_cur.st = fic_pkg::FIC_DONE;
            end else begin
               next_cur.flash_req = 1'b1;
               next_cur.st = fic_pkg::FIC_RUN;
            end
         end
         fic_pkg::FIC_RUN: begin
            // array handles read, program, erase timing
            if (flash_done_i) begin
               next_cur.flash_req = 1'b0;
               if (cur.prog_command_code == fic_pkg::CMD_READ) begin
                  next_cur.prog_data_word = flash_rdata_i;
               end
               next_cur.st = fic_pkg::FIC_DONE;
            end
         end
         fic_pkg::FIC_DONE: begin
            next_cur.prog_trigger_bit = 1'b0;
            next_cur.st = fic_pkg::FIC_IDLE;
         end
      endcase
      // read answer, one cycle later; reserved bits zero
      next_cur.rdata = fic_pkg::RESET_WORD;
      if (reg_read_i) begin
         unique case (reg_addr_i)
            fic_pkg::OFS_CONTROL: begin
               next_cur.rdata = {25'h0000000, cur.prog_fail_flag, cur.loader_update_enable,
                                 cur.config_update_enable, cur.app_update_enable, 1'b0,
                                 cur.boot_area_select, cur.prog_enable};
            end
            fic_pkg::OFS_ADDRESS: next_cur.rdata = cur.prog_target_address;
            fic_pkg::OFS_DATA:    next_cur.rdata = cur.prog_data_word;
            fic_pkg::OFS_COMMAND: next_cur.rdata = {26'h0000000, cur.prog_command_code};
            fic_pkg::OFS_TRIGGER: next_cur.rdata = {31'h00000000, cur.prog_trigger_bit};
            fic_pkg::OFS_DBASE:   next_cur.rdata = cur.data_area_base_address;
            fic_pkg::OFS_TIMING: begin
               next_cur.rdata = {25'h0000000, cur.freq_opt_mode_hi, 1'b0,
                                 cur.freq_opt_mode_lo, 4'h0};
            end
            fic_pkg::OFS_STATUS: begin
               next_cur.rdata = {11'h000, cur.vector_page_map, 2'b00, cur.prog_fail_flag,
                                 3'b000, chip_boot_selection_i,
                                 cur.prog_trigger_bit};
            end
            default: next_cur.rdata = fic_pkg::RESET_WORD; // unmapped reads zero
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register, constants only under reset
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   // outputs
   assign reg_rdata_o        = cur.rdata;
   assign flash_req_o        = cur.flash_req;
   assign flash_cmd_o        = cur.prog_command_code;
   assign flash_addr_o       = cur.prog_target_address;
   assign flash_wdata_o      = cur.prog_data_word;
   assign freq_opt_mode_o    = {cur.freq_opt_mode_hi, cur.freq_opt_mode_lo};
   assign vector_page_map_o  = cur.vector_page_map;
   assign boot_area_select_o = cur.boot_area_select;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   fail_on_error_a: assert property (cur.st == fic_pkg::FIC_CHECK && op_error
      |=> cur.prog_fail_flag && !cur.flash_req) else $error("error did not set fail flag");
   fail_sticky_a: assert property (cur.prog_fail_flag && !((wr_ctl || wr_sta) && protect_unlocked_i
      && reg_wdata_i[fic_pkg::BIT_FAIL]) |=> cur.prog_fail_flag) else $error("fail flag lost");
   // a clear loses only against a fail raised in the same cycle
   fail_clear_a: assert property ((wr_ctl || wr_sta) && protect_unlocked_i && reg_wdata_i[fic_pkg::BIT_FAIL]
      && !(cur.st == fic_pkg::FIC_CHECK && op_error) |=> !cur.prog_fail_flag)
      else $error("fail flag not cleared");
   trig_clears_a: assert property (cur.st == fic_pkg::FIC_DONE |=> !cur.prog_trigger_bit)
      else $error("trigger not cleared");
   busy_held_a: assert property (cur.st == fic_pkg::FIC_RUN |-> cur.prog_trigger_bit)
      else $error("trigger dropped while busy");
   no_start_disabled_a: assert property (cur.st == fic_pkg::FIC_IDLE && !cur.prog_enable
      |=> cur.st == fic_pkg::FIC_IDLE) else $error("started while disabled");
   read_result_a: assert property (cur.st == fic_pkg::FIC_RUN && flash_done_i
      && cur.prog_command_code == fic_pkg::CMD_READ |=> cur.prog_data_word == $past(flash_rdata_i))
      else $error("read word not stored");
   maker_code_a: assert property (cur.st == fic_pkg::FIC_CHECK && !op_error
      && cur.prog_command_code == fic_pkg::CMD_MAKER |=> cur.prog_data_word == MAKER_CODE)
      else $error("maker code wrong");
   remap_page_a: assert property (cur.st == fic_pkg::FIC_CHECK && !op_error
      && cur.prog_command_code == fic_pkg::CMD_REMAP |=> vector_page_map_o == $past(a[20:9]))
      else $error("remap page wrong");
   status_read_a: assert property (reg_read_i && reg_addr_i == fic_pkg::OFS_STATUS
      |=> reg_rdata_o[0] == $past(cur.prog_trigger_bit) && reg_rdata_o[6] == $past(cur.prog_fail_flag))
      else $error("status mirror wrong");

   // main scenarios: refused operation, array run, id read, remap, flag clear
   cover_error_c: cover property (cur.st == fic_pkg::FIC_CHECK && op_error);
   cover_prog_c:  cover property (cur.st == fic_pkg::FIC_RUN && flash_done_i);
   cover_uid_c:   cover property (cur.st == fic_pkg::FIC_CHECK && cur.prog_command_code == fic_pkg::CMD_UID);
   cover_remap_c: cover property (cur.st == fic_pkg::FIC_CHECK && cur.prog_command_code == fic_pkg::CMD_REMAP);
   cover_clear_c: cover property (cur.prog_fail_flag && wr_sta && reg_wdata_i[fic_pkg::BIT_FAIL]);
endmodule

/* File: tb/fic_flash_model.sv */
// behavioural flash array standing behind the programming controller
module fic_flash_model #(
   parameter int LATENCY = 5                      // done pulse comes LATENCY+1 cycles after the request
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   // request side
   input  wire logic        flash_req_i,
   input  wire logic [5:0]  flash_cmd_i,
   input  wire logic [31:0] flash_addr_i,
   input  wire logic [31:0] flash_wdata_i,
   // answer side
   output logic             flash_done_o,
   output logic [31:0]      flash_rdata_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] mem [16];                         // tiny array, word index from address bits 5..2
   int          cnt;                              // wait counter
   logic        seen;                             // request already answered
   ////////////////////////////////////////////////////////////////////////////
   // one done pulse per request level; read bus toggles while not presenting
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         flash_done_o <= 1'b0;
         flash_rdata_o <= 32'h0000_0000;
         cnt <= 0;
         seen <= 1'b0;
         for (int i = 0; i < 16; i++) mem[i] <= 32'hffff_ffff;
      end else begin
         flash_done_o <= 1'b0;
         flash_rdata_o <= ~flash_rdata_o;         // released bus shows no stale word
         if (!flash_req_i) begin
            seen <= 1'b0;
            cnt <= 0;
         end else if (!seen) begin
            cnt <= cnt + 1;
            if (cnt == LATENCY) begin
               flash_done_o <= 1'b1;
               seen <= 1'b1;
               // erase wipes everything: the array is far smaller than a page
               if (flash_cmd_i == fic_pkg::CMD_PROGRAM) mem[flash_addr_i[5:2]] <= flash_wdata_i;
               if (flash_cmd_i == fic_pkg::CMD_ERASE) for (int i = 0; i < 16; i++) mem[i] <= 32'hffff_ffff;
               if (flash_cmd_i == fic_pkg::CMD_READ) flash_rdata_o <= mem[flash_addr_i[5:2]];
            end
         end
      end
   end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the flash programming controller
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i = 1'b0, reset_n_i = 1'b0, reg_write_i = 1'b0, reg_read_i = 1'b0;
   logic [7:0]  reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, second_config_word_i = 32'h0001_e000;
   logic        cold_reset_i = 1'b1, running_from_loader_i = 1'b1, protect_unlocked_i = 1'b0;
   logic [1:0]  chip_boot_selection_i = 2'b01, freq_opt_mode_o;
   logic        flash_req_o, flash_done_i, boot_area_select_o, req_q = 1'b0;
   logic [5:0]  flash_cmd_o, cap_cmd;
   logic [31:0] flash_addr_o, flash_wdata_o, flash_rdata_i, cap_addr, cap_wdata, small_rdata;
   logic [11:0] vector_page_map_o;
   logic [95:0] uid = 96'h3333_0003_2222_0002_1111_0001;
   int          errors = 0, checked = 0, starts = 0, cycles = 0, s0;
   always #20 clk_i = ~clk_i;                      // 25 MHz
   fic_ctrl u_fic_ctrl (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
      .reg_rdata_o(reg_rdata_o), .cold_reset_i(cold_reset_i), .chip_boot_selection_i(chip_boot_selection_i),
      .second_config_word_i(second_config_word_i), .running_from_loader_i(running_from_loader_i),
      .protect_unlocked_i(protect_unlocked_i), .flash_req_o(flash_req_o), .flash_cmd_o(flash_cmd_o),
      .flash_addr_o(flash_addr_o), .flash_wdata_o(flash_wdata_o), .flash_done_i(flash_done_i),
      .flash_rdata_i(flash_rdata_i), .unique_id_i(uid), .freq_opt_mode_o(freq_opt_mode_o),
      .vector_page_map_o(vector_page_map_o), .boot_area_select_o(boot_area_select_o));
   fic_flash_model u_fic_flash_model (.clk_i(clk_i), .reset_n_i(reset_n_i), .flash_req_i(flash_req_o),
      .flash_cmd_i(flash_cmd_o), .flash_addr_i(flash_addr_o), .flash_wdata_i(flash_wdata_o),
      .flash_done_o(flash_done_i), .flash_rdata_o(flash_rdata_i));
   // small part: fixed data area base; its array answers at once
   fic_ctrl #(.LARGE_PART(1'b0)) u_fic_ctrl_small (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
      .reg_rdata_o(small_rdata), .cold_reset_i(cold_reset_i), .chip_boot_selection_i(chip_boot_selection_i),
      .second_config_word_i(second_config_word_i), .running_from_loader_i(running_from_loader_i),
      .protect_unlocked_i(protect_unlocked_i), .flash_req_o(), .flash_cmd_o(), .flash_addr_o(),
      .flash_wdata_o(), .flash_done_i(1'b1), .flash_rdata_i(32'h0000_0000), .unique_id_i(uid),
      .freq_opt_mode_o(), .vector_page_map_o(), .boot_area_select_o());
   ////////////////////////////////////////////////////////////////////////////
   // count flash starts and capture what each start carried; timeout guard
   always @(posedge clk_i) begin
      req_q <= flash_req_o;
      if (flash_req_o === 1'b1 && req_q !== 1'b1) begin
         starts <= starts + 1;
         cap_cmd <= flash_cmd_o;
         cap_addr <= flash_addr_o;
         cap_wdata <= flash_wdata_o;
      end
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         test_done();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // bus tasks: one-cycle strobes launched right after an edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_write_i <= 1'b1;
      @(posedge clk_i);
      reg_write_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_read_i <= 1'b1;
      @(posedge clk_i);
      reg_read_i <= 1'b0;
      #1 d = reg_rdata_o;                          // data stand only in this cycle
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      chk($sformatf("reg %h", a), e, d);
   endtask
   // full operation: trigger must read busy first, then self-clear in bounded time
   task automatic op(input logic [5:0] c, input logic [31:0] a);
      int n;
      logic [31:0] d;
      wr(fic_pkg::OFS_COMMAND, {26'h0, c});
      wr(fic_pkg::OFS_ADDRESS, a);
      wr(fic_pkg::OFS_TRIGGER, 32'h1);
      rd(fic_pkg::OFS_TRIGGER, d);
      chk("trigger busy", 32'h1, d);
      n = 0;
      while (d !== 32'h0 && n < 40) begin
         rd(fic_pkg::OFS_TRIGGER, d);
         n++;
      end
      chk("trigger cleared", 32'h0, d);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (16) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rchk(fic_pkg::OFS_CONTROL, 32'h2);
      chk("boot select out", 32'h1, {31'h0, boot_area_select_o});
      rchk(fic_pkg::OFS_STATUS, 32'h2);
      rchk(fic_pkg::OFS_DBASE, 32'h0001_e000);
      chk("small part base", 32'h0001_f000, small_rdata);
      for (int i = 1; i < 7; i++) if (i != 5) rchk(8'(4 * i), 32'h0);
      rchk(8'h20, 32'h0);
      wr(fic_pkg::OFS_DBASE, 32'hffff_ffff);
      rchk(fic_pkg::OFS_DBASE, 32'h0001_e000);
      $display("test reset values done");
      wr(fic_pkg::OFS_CONTROL, 32'h39);
      rchk(fic_pkg::OFS_CONTROL, 32'h2);
      @(posedge clk_i) protect_unlocked_i <= 1'b1;
      wr(fic_pkg::OFS_CONTROL, 32'hffff_ffff);
      rchk(fic_pkg::OFS_CONTROL, 32'h3b);
      chk("boot select out", 32'h1, {31'h0, boot_area_select_o});
      wr(fic_pkg::OFS_CONTROL, 32'h39);
      rchk(fic_pkg::OFS_CONTROL, 32'h39);
      chk("boot select out", 32'h0, {31'h0, boot_area_select_o});
      for (int i = 0; i < 4; i++) begin
         wr(fic_pkg::OFS_TIMING, 32'hffff_ffaf | {25'h0, i[1], 1'b0, i[0], 4'h0});
         rchk(fic_pkg::OFS_TIMING, {25'h0, i[1], 1'b0, i[0], 4'h0});
         chk("freq mode out", i, {30'h0, freq_opt_mode_o});
      end
      wr(fic_pkg::OFS_ADDRESS, 32'ha5a5_5a5c);
      rchk(fic_pkg::OFS_ADDRESS, 32'ha5a5_5a5c);
      wr(fic_pkg::OFS_COMMAND, 32'hffff_ffff);
      rchk(fic_pkg::OFS_COMMAND, 32'h3f);
      $display("test registers done");
      wr(fic_pkg::OFS_DATA, 32'hcafe_0001);
      op(fic_pkg::CMD_PROGRAM, 32'h0000_0104);
      chk("flash cmd", 32'h21, {26'h0, cap_cmd});
      chk("flash addr", 32'h104, cap_addr);
      chk("flash wdata", 32'hcafe_0001, cap_wdata);
      wr(fic_pkg::OFS_DATA, 32'h0);
      op(fic_pkg::CMD_READ, 32'h0000_0104);
      rchk(fic_pkg::OFS_DATA, 32'hcafe_0001);
      op(fic_pkg::CMD_ERASE, 32'h0);
      op(fic_pkg::CMD_READ, 32'h0000_0104);
      rchk(fic_pkg::OFS_DATA, 32'hffff_ffff);
      for (int i = 0; i < 3; i++) begin
         op(fic_pkg::CMD_UID, 32'h4 * i);
         rchk(fic_pkg::OFS_DATA, uid[32 * i +: 32]);
      end
      op(fic_pkg::CMD_MAKER, 32'h0);
      rchk(fic_pkg::OFS_DATA, 32'h0000_005a);
      chk("flash starts", 32'd4, starts);
      op(fic_pkg::CMD_REMAP, 32'h0000_3400);
      chk("vector page out", 32'h1a, {20'h0, vector_page_map_o});
      rchk(fic_pkg::OFS_STATUS, 32'h3402);
      $display("test operations done");
      s0 = starts;
      @(posedge clk_i) running_from_loader_i <= 1'b0;
      wr(fic_pkg::OFS_CONTROL, 32'h31);
      op(fic_pkg::CMD_PROGRAM, 32'h0000_0200);
      rchk(fic_pkg::OFS_CONTROL, 32'h71);
      rchk(fic_pkg::OFS_STATUS, 32'h3442);
      wr(fic_pkg::OFS_STATUS, 32'h40);
      rchk(fic_pkg::OFS_CONTROL, 32'h31);
      wr(fic_pkg::OFS_CONTROL, 32'h29);
      op(fic_pkg::CMD_PROGRAM, 32'h0030_0000);
      rchk(fic_pkg::OFS_CONTROL, 32'h69);
      wr(fic_pkg::OFS_CONTROL, 32'h79);
      rchk(fic_pkg::OFS_CONTROL, 32'h39);
      op(fic_pkg::CMD_PROGRAM, 32'h0005_0000);
      rchk(fic_pkg::OFS_CONTROL, 32'h79);
      chk("flash starts", s0, starts);
      wr(fic_pkg::OFS_CONTROL, 32'h79);
      op(fic_pkg::CMD_PROGRAM, 32'h0000_0208);
      rchk(fic_pkg::OFS_CONTROL, 32'h39);
      chk("flash starts", s0 + 1, starts);
      @(posedge clk_i) running_from_loader_i <= 1'b1;
      wr(fic_pkg::OFS_CONTROL, 32'h19);
      op(fic_pkg::CMD_PROGRAM, 32'h0010_0000);
      rchk(fic_pkg::OFS_CONTROL, 32'h59);
      $display("test faults done");
      wr(fic_pkg::OFS_CONTROL, 32'h78);
      wr(fic_pkg::OFS_TRIGGER, 32'h1);
      rchk(fic_pkg::OFS_TRIGGER, 32'h0);
      rchk(fic_pkg::OFS_CONTROL, 32'h38);
      chk("flash starts", s0 + 1, starts);
      $display("test disable done");
      // second reset while idle with the other boot selection strapped
      @(posedge clk_i) reset_n_i <= 1'b0;
      chip_boot_selection_i <= 2'b11;
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rchk(fic_pkg::OFS_CONTROL, 32'h0);
      rchk(fic_pkg::OFS_STATUS, 32'h6);
      $display("test second reset done");
      test_done();
   end
endmodule
